/* File: src/bdm_data_memory.sv */
// banked data memory: core registers, general ram, common ram and pointer ports
// assumes one access per cycle from the core datapath, all inputs synchronous
// rams are not cleared by reset, so software must set them up before use
`timescale 1ns/100ps

// Operation
// - thirty-two banks of 128 bytes
// - direct bank from last bank select write
// - unimplemented locations read as zero
// - twelve-bit address, bank plus offset
// - core registers at offsets 0..11, every bank
// - offsets 0Ch..1Fh reserved for peripherals
// - up to eighty general bytes per bank
// - sixteen common bytes seen from all banks
// - memory reachable directly or via pointers
// - flag ops suppress status write to flags
// - expiry and slept flags are read-only
// - status wipe gives 000u u1uu
// - expiry set by power-up/kick/sleep, cleared timeout
// - slept set power-up/kick, cleared by sleep
// - zero flag follows result equal zero
// - nibble flag is carry out of bit 3
// - carry flag is carry out of bit 7
// - subtract adds two's complement, inverted borrows
// - status bits 7..5 read zero
// - power-on sets expiry/slept, clears arithmetic flags
module bdm_data_memory (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // reset causes and core events
  input wire logic warmRst,
  input wire logic warmExpiry,
  input wire logic warmSlept,
  input wire logic watchdogKickInstr,
  input wire logic sleepInstr,
  input wire logic watchdogTimeout,
  // access request
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [6:0] accOfs,
  input wire logic [7:0] accData,
  // flag-producing operation
  input wire bdm_pkg::bdm_op_t aluOp,
  input wire logic [7:0] aluA,
  input wire logic [7:0] aluB,
  // read answer and core register view
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [7:0] statusVal,
  output logic [4:0] bankSel,
  output logic [15:0] ptr0Addr,
  output logic [15:0] ptr1Addr,
  output logic [7:0] accumVal,
  output logic [7:0] pcLow,
  output logic [7:0] pcLatch,
  output logic [7:0] intCtl
);
  import bdm_pkg::*;

  bdm_core_t cur_ff;
  bdm_core_t nxt_cur;

  // map of one bank, the same in all thirty-two:
  //   00h..01h  pointer ports, swapped for the pointed-at location
  //   02h..0Bh  core registers, one physical copy shared by every bank
  //   0Ch..1Fh  peripheral area, not built here, reads zero and drops writes
  //   20h..6Fh  general ram, eighty bytes private to each bank
  //   70h..7Fh  common ram, sixteen bytes aliased into every bank
  // a pointer holds bank in bits 11..7 and offset in bits 6..0; bits 15..12
  // select spaces this block does not hold, so such a pointer reaches nothing
  // a pointer aimed at a pointer port would need a second lookup in the same
  // cycle, so it is treated as unimplemented rather than chained
  // limitation: the peripheral area is empty here, peripherals sit elsewhere
  // trade-off: one access per cycle keeps the decode purely combinational

  // general ram is large, so it lives in arrays outside the state record
  logic [7:0] gprMem [0:GPR_TOTAL-1];
  logic [7:0] commonMem [0:COMMON_BYTES-1];

  // effective address after pointer substitution
  logic [11:0] effAddr;
  logic [4:0] effBank;
  logic [6:0] effOfs;
  logic badPtr;

  // region decode
  logic isCore;
  logic isGpr;
  logic isCommon;

  // array indexes
  logic [11:0] gprIdx;
  logic [3:0] commonIdx;

  // write path
  logic [7:0] wrVal;
  logic [7:0] aluRes;
  logic wrCore;
  logic wrGpr;
  logic wrCommon;
  logic wrStatus;

  // read path
  logic [7:0] coreRd;
  logic [7:0] memRd;

  // address forming: pointer ports swap in the pointer, else bank plus offset
  // the bank register only steers direct accesses; pointers carry their own
  // bits 15..12 of a pointer are checked here so decode can drop the access
  always_comb begin
    effAddr = {cur_ff.bank, accOfs};
    badPtr = 1'b0;
    if (accOfs == OFS_PTR0_PORT) begin
      effAddr = cur_ff.ptr0[11:0];
      badPtr = (cur_ff.ptr0[15:12] != 4'h0);
    end else if (accOfs == OFS_PTR1_PORT) begin
      effAddr = cur_ff.ptr1[11:0];
      badPtr = (cur_ff.ptr1[15:12] != 4'h0);
    end
    effBank = effAddr[11:7];
    effOfs = effAddr[6:0];
  end

  // region decode; a pointer aimed at a pointer port lands nowhere
  // order matters: the tests run from the bottom of the bank upward
  always_comb begin
    isCore = 1'b0;
    isGpr = 1'b0;
    isCommon = 1'b0;
    if (badPtr) begin
      isCore = 1'b0;
    end else if (effOfs < OFS_PERIPH_BASE) begin
      isCore = (effOfs != OFS_PTR0_PORT) && (effOfs != OFS_PTR1_PORT);
    end else if (effOfs < OFS_GPR_BASE) begin
      isCore = 1'b0;
    end else if (effOfs < OFS_COMMON_BASE) begin
      isGpr = 1'b1;
    end else begin
      isCommon = 1'b1;
    end
  end

  // each bank's general ram packed back to back, common ram ignores bank;
  // indexes rest at zero outside their region so a stray offset never
  // produces an out-of-range array index in the read mux
  always_comb begin
    gprIdx = 12'h000;
    commonIdx = 4'h0;
    if (isGpr) begin
      gprIdx = 12'(effBank) * GPR_BANK_BYTES + 12'(effOfs - OFS_GPR_BASE);
    end
    if (isCommon) begin
      commonIdx = effOfs[3:0];
    end
  end

  // a flag-producing op writes its own result, not the raw data; the strobes
  // are split by region so each store sees only its own writes
  always_comb begin
    wrVal = accData;
    wrCore = 1'b0;
    wrGpr = 1'b0;
    wrCommon = 1'b0;
    wrStatus = 1'b0;
    if (aluOp != BDM_OP_NONE) begin
      wrVal = aluRes;
    end
    if (accValid && accWrite) begin
      wrCore = isCore;
      wrGpr = isGpr;
      wrCommon = isCommon;
      wrStatus = isCore && (effOfs == OFS_STATUS);
    end
  end

  // the status register lives in its own module; it sees every write aimed
  // at the status offset and decides per bit what lands, since the flag
  // outcome of an op beats the data and the two reset-cause flags take none
  // its result feeds the write path, whose value lands in ram and core registers; the flag bits take the op outcome
  bdm_status u_status (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .warmRst(warmRst),
    .warmExpiry(warmExpiry),
    .warmSlept(warmSlept),
    .watchdogKickInstr(watchdogKickInstr),
    .sleepInstr(sleepInstr),
    .watchdogTimeout(watchdogTimeout),
    .wrEn(wrStatus),
    .wrData(wrVal),
    .aluOp(aluOp),
    .aluA(aluA),
    .aluB(aluB),
    .aluRes(aluRes),
    .statusVal(statusVal)
  );

  // core register read mux; bank select shows only its five live bits
  // pointer ports are absent here: they were swapped for their target above
  always_comb begin
    coreRd = 8'h00;
    case (effOfs)
      OFS_PC_LOW: begin
        coreRd = cur_ff.pcLow;
      end
      OFS_STATUS: begin
        coreRd = statusVal;
      end
      OFS_PTR0_LOW: begin
        coreRd = cur_ff.ptr0[7:0];
      end
      OFS_PTR0_HIGH: begin
        coreRd = cur_ff.ptr0[15:8];
      end
      OFS_PTR1_LOW: begin
        coreRd = cur_ff.ptr1[7:0];
      end
      OFS_PTR1_HIGH: begin
        coreRd = cur_ff.ptr1[15:8];
      end
      OFS_BANK_SEL: begin
        coreRd = {3'b000, cur_ff.bank};
      end
      OFS_ACCUM: begin
        coreRd = cur_ff.accum;
      end
      OFS_PC_LATCH: begin
        coreRd = cur_ff.pcLatch;
      end
      OFS_INT_CTL: begin
        coreRd = cur_ff.intCtl;
      end
      default: begin
        coreRd = 8'h00;
      end
    endcase
  end

  // whole read mux; peripheral space and stray pointers give zero
  always_comb begin
    memRd = 8'h00;
    if (isCore) begin
      memRd = coreRd;
    end else if (isGpr) begin
      memRd = gprMem[gprIdx];
    end else if (isCommon) begin
      memRd = commonMem[commonIdx];
    end
  end

  // next state: core register writes and the registered read answer
  // rdData holds its value between reads so a slow consumer can still take it
  // writes to the status offset fall through to default; the status module
  // takes them instead
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rdValid = accValid && !accWrite;
    if (accValid && !accWrite) begin
      nxt_cur.rdData = memRd;
    end
    if (wrCore) begin
      case (effOfs)
        OFS_PC_LOW: begin
          nxt_cur.pcLow = wrVal;
        end
        OFS_PTR0_LOW: begin
          nxt_cur.ptr0[7:0] = wrVal;
        end
        OFS_PTR0_HIGH: begin
          nxt_cur.ptr0[15:8] = wrVal;
        end
        OFS_PTR1_LOW: begin
          nxt_cur.ptr1[7:0] = wrVal;
        end
        OFS_PTR1_HIGH: begin
          nxt_cur.ptr1[15:8] = wrVal;
        end
        OFS_BANK_SEL: begin
          nxt_cur.bank = wrVal[4:0];
        end
        OFS_ACCUM: begin
          nxt_cur.accum = wrVal;
        end
        OFS_PC_LATCH: begin
          nxt_cur.pcLatch = wrVal;
        end
        OFS_INT_CTL: begin
          nxt_cur.intCtl = wrVal;
        end
        default: begin
          nxt_cur.accum = cur_ff.accum;
        end
      endcase
    end
  end

  // state record register
  // read answer clears in reset so no stale valid leaks out after release
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_ff.pcLow <= RST_CORE_BYTE;
      cur_ff.pcLatch <= RST_CORE_BYTE;
      cur_ff.intCtl <= RST_CORE_BYTE;
      cur_ff.ptr0 <= RST_POINTER;
      cur_ff.ptr1 <= RST_POINTER;
      cur_ff.bank <= RST_BANK;
      cur_ff.accum <= RST_CORE_BYTE;
      cur_ff.rdData <= RST_CORE_BYTE;
      cur_ff.rdValid <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ram contents are not cleared by reset, as in most core ram
  // clearing thousands of bytes would need a long sweep after every reset
  // and a matching busy signal, which the datapath has no way to honour
  always_ff @(posedge ref_clk) begin
    if (wrGpr) begin
      gprMem[gprIdx] <= wrVal;
    end
    if (wrCommon) begin
      commonMem[commonIdx] <= wrVal;
    end
  end

  // outputs straight from flip-flops
  // read answer
  assign rdData = cur_ff.rdData;
  assign rdValid = cur_ff.rdValid;

  // addressing state
  assign bankSel = cur_ff.bank;
  assign ptr0Addr = cur_ff.ptr0;
  assign ptr1Addr = cur_ff.ptr1;

  // remaining core registers
  assign accumVal = cur_ff.accum;
  assign pcLow = cur_ff.pcLow;
  assign pcLatch = cur_ff.pcLatch;
  assign intCtl = cur_ff.intCtl;
endmodule

/* File: src/bdm_pkg.sv */
// constants and types shared by the banked data memory and its status flags
// assumes one core clock; the core datapath is the only client
package bdm_pkg;
  // address split: bank in bits 11..7, offset in bits 6..0
  localparam int ADDR_W = 12;
  localparam int BANK_W = 5;
  localparam int OFS_W = 7;
  localparam int NUM_BANKS = 32;
  localparam int BANK_BYTES = 128;
  // core register offsets, repeated in every bank
  localparam logic [6:0] OFS_PTR0_PORT = 7'h00;
  localparam logic [6:0] OFS_PTR1_PORT = 7'h01;
  localparam logic [6:0] OFS_PC_LOW = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_PTR0_LOW = 7'h04;
  localparam logic [6:0] OFS_PTR0_HIGH = 7'h05;
  localparam logic [6:0] OFS_PTR1_LOW = 7'h06;
  localparam logic [6:0] OFS_PTR1_HIGH = 7'h07;
  localparam logic [6:0] OFS_BANK_SEL = 7'h08;
  localparam logic [6:0] OFS_ACCUM = 7'h09;
  localparam logic [6:0] OFS_PC_LATCH = 7'h0A;
  localparam logic [6:0] OFS_INT_CTL = 7'h0B;
  // region bases inside a bank
  localparam logic [6:0] OFS_PERIPH_BASE = 7'h0C;
  localparam logic [6:0] OFS_GPR_BASE = 7'h20;
  localparam logic [6:0] OFS_COMMON_BASE = 7'h70;
  localparam logic [11:0] GPR_BANK_BYTES = 12'h050;
  localparam int GPR_TOTAL = 2560;
  localparam int COMMON_BYTES = 16;
  // status bit positions
  localparam int ST_TO_BIT = 4;
  localparam int ST_PD_BIT = 3;
  localparam int ST_Z_BIT = 2;
  localparam int ST_DC_BIT = 1;
  localparam int ST_C_BIT = 0;
  // values after power-on or brown-out reset
  localparam logic RST_EXPIRY = 1'h1;
  localparam logic RST_SLEPT = 1'h1;
  localparam logic RST_ARITH = 1'h0;
  localparam logic [7:0] RST_CORE_BYTE = 8'h00;
  localparam logic [15:0] RST_POINTER = 16'h0000;
  localparam logic [4:0] RST_BANK = 5'h00;
  // flag-producing operations issued by the datapath
  typedef enum logic [1:0] {
    BDM_OP_NONE = 2'h0,
    BDM_OP_ADD = 2'h1,
    BDM_OP_SUB = 2'h2,
    BDM_OP_LOGIC = 2'h3
  } bdm_op_t;
  typedef struct packed {
    logic expiry;
    logic slept;
    logic zero;
    logic nibble;
    logic carry;
  } bdm_stat_t;
  typedef struct packed {
    logic [7:0] pcLow;
    logic [7:0] pcLatch;
    logic [7:0] intCtl;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [4:0] bank;
    logic [7:0] accum;
    logic [7:0] rdData;
    logic rdValid;
  } bdm_core_t;
endpackage

/* File: src/bdm_status.sv */
// arithmetic status register with flag logic for add, subtract and logic ops
// assumes the datapath presents operands and op in the same cycle as the write
`timescale 1ns/100ps
module bdm_status (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic warmRst,
  input wire logic warmExpiry,
  input wire logic warmSlept,
  input wire logic watchdogKickInstr,
  input wire logic sleepInstr,
  input wire logic watchdogTimeout,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire bdm_pkg::bdm_op_t aluOp,
  input wire logic [7:0] aluA,
  input wire logic [7:0] aluB,
  output logic [7:0] aluRes,
  output logic [7:0] statusVal
);
  import bdm_pkg::*;

  bdm_stat_t cur_ff;
  bdm_stat_t nxt_cur;
  logic [8:0] sum9;
  logic [4:0] nib5;

  // subtract adds the two's complement, so carries read as inverted borrows
  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    case (aluOp)
      BDM_OP_ADD: begin
        sum9 = {1'b0, aluA} + {1'b0, aluB};
        nib5 = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
      end
      BDM_OP_SUB: begin
        sum9 = {1'b0, aluA} + {1'b0, ~aluB} + 9'h001;
        nib5 = {1'b0, aluA[3:0]} + {1'b0, ~aluB[3:0]} + 5'h01;
      end
      BDM_OP_LOGIC: begin
        sum9 = {1'b0, aluB};
      end
      default: begin
        sum9 = 9'h000;
      end
    endcase
    aluRes = sum9[7:0];
  end

  // a flag-producing op owns the three arithmetic bits; a write cannot land on them
  always_comb begin
    nxt_cur = cur_ff;
    if (aluOp != BDM_OP_NONE) begin
      nxt_cur.zero = (sum9[7:0] == 8'h00);
      if (aluOp != BDM_OP_LOGIC) begin
        nxt_cur.nibble = nib5[4];
        nxt_cur.carry = sum9[8];
      end
    end else if (wrEn) begin
      nxt_cur.zero = wrData[ST_Z_BIT];
      nxt_cur.nibble = wrData[ST_DC_BIT];
      nxt_cur.carry = wrData[ST_C_BIT];
    end
    // expiry and slept ignore writes entirely
    if (watchdogKickInstr) begin
      nxt_cur.expiry = 1'b1;
      nxt_cur.slept = 1'b1;
    end
    if (sleepInstr) begin
      nxt_cur.expiry = 1'b1;
      nxt_cur.slept = 1'b0;
    end
    if (watchdogTimeout) begin
      nxt_cur.expiry = 1'b0;
    end
    // warm resets report their cause and keep the arithmetic flags
    if (warmRst) begin
      nxt_cur.expiry = warmExpiry;
      nxt_cur.slept = warmSlept;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_ff.expiry <= RST_EXPIRY;
      cur_ff.slept <= RST_SLEPT;
      cur_ff.zero <= RST_ARITH;
      cur_ff.nibble <= RST_ARITH;
      cur_ff.carry <= RST_ARITH;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // upper three bits are not implemented
  assign statusVal = {3'b000, cur_ff.expiry, cur_ff.slept, cur_ff.zero,
                      cur_ff.nibble, cur_ff.carry};
endmodule

/* File: tb/bdm_data_memory_monitor.sv */
// checker on the banked data memory top ports
// assumes one core clock and a synchronous high reset
`timescale 1ns/100ps
module bdm_data_memory_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic warmRst,
  input wire logic watchdogKickInstr,
  input wire logic sleepInstr,
  input wire logic watchdogTimeout,
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [6:0] accOfs,
  input wire logic [7:0] accData,
  input wire bdm_pkg::bdm_op_t aluOp,
  input wire logic [7:0] aluA,
  input wire logic [7:0] aluB,
  input wire logic rdValid,
  input wire logic [7:0] statusVal,
  input wire logic [4:0] bankSel,
  input wire logic [7:0] accumVal
);
  import bdm_pkg::*;
  logic [8:0] addSum;
  logic [4:0] addNib;
  logic [2:0] addFlags;
  logic subNb;
  logic quiet;
  logic plainWr;
  // flag outcomes worked out beside the design
  assign addSum = {1'h0, aluA} + {1'h0, aluB};
  assign addNib = {1'h0, aluA[3:0]} + {1'h0, aluB[3:0]};
  assign addFlags = {addSum[7:0] == 8'h00, addNib[4], addSum[8]};
  assign subNb = aluA >= aluB;
  assign quiet = !warmRst && !watchdogTimeout && !sleepInstr && !watchdogKickInstr;
  assign plainWr = accValid && accWrite && aluOp == BDM_OP_NONE;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_RD_ANSWER: assert property (accValid && !accWrite |=> rdValid)
    else $error("read not answered next cycle");
  AST_RD_ONLY: assert property (!(accValid && !accWrite) |=> !rdValid)
    else $error("read valid without a read");
  AST_BANK: assert property (plainWr && accOfs == OFS_BANK_SEL
    |=> {3'h0, bankSel} == ($past(accData) & 8'h1F)) else $error("bank select not taken");
  AST_ACCUM: assert property (plainWr && accOfs == OFS_ACCUM
    |=> accumVal == $past(accData)) else $error("accumulator not written");
  AST_TOP_ZERO: assert property (statusVal[7:5] == 3'h0)
    else $error("status upper bits set");
  AST_FLAGS_RO: assert property (plainWr && accOfs == OFS_STATUS && quiet
    |=> $stable(statusVal[4:3])) else $error("reset flags written");
  AST_KICK: assert property (watchdogKickInstr && !warmRst && !watchdogTimeout &&
    !sleepInstr |=> statusVal[4:3] == 2'h3) else $error("kick flags wrong");
  AST_SLEEP: assert property (sleepInstr && !warmRst && !watchdogTimeout
    |=> statusVal[4:3] == 2'h2) else $error("sleep flags wrong");
  AST_TIMEOUT: assert property (watchdogTimeout && !warmRst |=> !statusVal[4])
    else $error("timeout kept expiry flag");
  AST_ADD: assert property (aluOp == BDM_OP_ADD
    |=> statusVal[2:0] == $past(addFlags)) else $error("add flags wrong");
  AST_SUB: assert property (aluOp == BDM_OP_SUB |=> statusVal[0] == $past(subNb))
    else $error("borrow polarity wrong");
  AST_POR: assert property (disable iff (1'b0) sys_rst
    |=> statusVal == 8'h18 && bankSel == 5'h00) else $error("power-on values wrong");
  // main scenarios
  cover property (accValid && !accWrite && accOfs == OFS_PTR0_PORT);
  cover property (aluOp == BDM_OP_SUB);
  cover property (watchdogTimeout);
endmodule
bind bdm_data_memory bdm_data_memory_monitor i_bdm_data_memory_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .warmRst(warmRst),
  .watchdogKickInstr(watchdogKickInstr), .sleepInstr(sleepInstr),
  .watchdogTimeout(watchdogTimeout), .accValid(accValid), .accWrite(accWrite),
  .accOfs(accOfs), .accData(accData), .aluOp(aluOp), .aluA(aluA), .aluB(aluB),
  .rdValid(rdValid), .statusVal(statusVal), .bankSel(bankSel), .accumVal(accumVal));

/* File: tb/bdm_core_model.sv */
// model of the core datapath issuing accesses and reset events
// assumes the bench calls drive just after a rising edge
`timescale 1ns/100ps
module bdm_core_model (
  output logic accValid,
  output logic accWrite,
  output logic [6:0] accOfs,
  output logic [7:0] accData,
  output bdm_pkg::bdm_op_t aluOp,
  output logic [7:0] aluA,
  output logic [7:0] aluB,
  output logic [5:0] evBus
);
  import bdm_pkg::*;
  // quiet at time zero
  initial begin
    {accValid, accWrite, accOfs, accData, aluA, aluB, evBus} = '0;
    aluOp = BDM_OP_NONE;
  end
  // one request per call, held until the next call
  task automatic drive(input bit v, w, input logic [6:0] o, input logic [7:0] d,
      input bdm_op_t op, input logic [7:0] a, b, input logic [5:0] ev);
    accValid = v;
    accWrite = w && v;
    // an idle bus keeps changing, so a stale byte is never taken for data
    accOfs = v ? o : ~accOfs;
    accData = v ? d : ~accData;
    aluOp = op;
    aluA = a;
    aluB = b;
    evBus = ev;
  endtask
endmodule

/* File: tb/test_bdm_data_memory.sv */
// bench for the banked data memory with an integer reference model
// assumes bdm_pkg, the design and the core model are compiled first
`timescale 1ns/100ps
module test_bdm_data_memory;
  import bdm_pkg::*;
  logic ref_clk, sys_rst, accValid, accWrite, rdValid;
  logic [6:0] accOfs;
  logic [7:0] accData, aluA, aluB, rdData, statusVal, accumVal, pcLow, pcLatch, intCtl;
  logic [5:0] evBus;
  logic [4:0] bankSel;
  logic [15:0] ptr0Addr, ptr1Addr;
  bdm_op_t aluOp;
  int ram[4096];
  int st, bk, p0, p1, acc, program_counter_low, pch, ic, expRd, num_errors, checks_done;
  bit expRv;
  int evTab[6] = '{2, 4, 1, 8, 56, 40};
  bdm_core_model i_bdm_core_model (.accValid(accValid), .accWrite(accWrite),
    .accOfs(accOfs), .accData(accData), .aluOp(aluOp), .aluA(aluA), .aluB(aluB),
    .evBus(evBus));
  bdm_data_memory i_bdm_data_memory (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .warmRst(evBus[3]), .warmExpiry(evBus[5]), .warmSlept(evBus[4]),
    .watchdogKickInstr(evBus[0]), .sleepInstr(evBus[1]), .watchdogTimeout(evBus[2]),
    .accValid(accValid), .accWrite(accWrite), .accOfs(accOfs), .accData(accData),
    .aluOp(aluOp), .aluA(aluA), .aluB(aluB), .rdData(rdData), .rdValid(rdValid),
    .statusVal(statusVal), .bankSel(bankSel), .ptr0Addr(ptr0Addr), .ptr1Addr(ptr1Addr),
    .accumVal(accumVal), .pcLow(pcLow), .pcLatch(pcLatch), .intCtl(intCtl));
  // 250 MHz core clock
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(string nm, logic [79:0] seen, logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // reference read; pointer ports recurse once into the pointed location
  function automatic int rdLoc(int b, int o);
    int p;
    if (o < 2) begin
      p = o ? p1 : p0;
      if (p[15:12] != 0 || p[6:0] < 2) return 0;
      return rdLoc(p[11:7], p[6:0]);
    end
    case (o)
      2: return program_counter_low;
      3: return st;
      4: return p0 & 8'hFF;
      5: return p0 >> 8;
      6: return p1 & 8'hFF;
      7: return p1 >> 8;
      8: return bk;
      9: return acc;
      10: return pch;
      11: return ic;
      default: ;
    endcase
    if (o < 32) return 0;
    return o >= 112 ? ram[o] : ram[b * 128 + o];
  endfunction
  // reference write; refused places drop the byte
  task automatic wrLoc(int b, int o, int d);
    int p;
    p = o ? p1 : p0;
    if (o < 2 && p[15:12] == 0 && p[6:0] >= 2) wrLoc(p[11:7], p[6:0], d);
    case (o)
      0, 1: ;
      2: program_counter_low = d;
      3: st = (st & 8'h18) | (d & 7);
      4: p0 = (p0 & 16'hFF00) | d;
      5: p0 = (p0 & 8'hFF) | d << 8;
      6: p1 = (p1 & 16'hFF00) | d;
      7: p1 = (p1 & 8'hFF) | d << 8;
      8: bk = d & 8'h1F;
      9: acc = d;
      10: pch = d;
      11: ic = d;
      default: if (o >= 32) ram[o >= 112 ? o : b * 128 + o] = d;
    endcase
  endtask
  // check last cycle's results, issue one request, advance the model
  task automatic step(bit v, w, int o, d, op = 0, a = 0, b = 0, ev = 0);
    int res, z, n, c;
    @(posedge ref_clk);
    #1;
    if (expRv) check("rdData", rdData, expRd);
    check("rdValid", rdValid, expRv);
    check("state", {statusVal, bankSel, ptr0Addr, ptr1Addr, accumVal, pcLow, pcLatch,
      intCtl}, {st[7:0], bk[4:0], p0[15:0], p1[15:0], acc[7:0], program_counter_low[7:0], pch[7:0], ic[7:0]});
    i_bdm_core_model.drive(v, w, o, d, bdm_op_t'(op), a, b, ev);
    expRv = v && !w;
    if (expRv) expRd = rdLoc(bk, o);
    n = st >> 1 & 1;
    c = st & 1;
    res = op == 1 ? a + b : op == 2 ? a + (~b & 8'hFF) + 1 : b;
    if (op == 1) n = ((a & 15) + (b & 15)) >> 4;
    if (op == 2) n = ((a & 15) + (~b & 15) + 1) >> 4;
    if (op == 1 || op == 2) c = res >> 8;
    z = (res & 8'hFF) == 0;
    if (v && w) wrLoc(bk, o, op ? res & 8'hFF : d);
    if (op) st = (st & 8'h18) | z << 2 | n << 1 | c;
    if (ev[3]) st = (st & 7) | ev[5:4] << 3;
    else if (ev[2]) st = st & 8'hEF;
    else if (ev[1]) st = (st & 7) | 8'h10;
    else if (ev[0]) st = st | 8'h18;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'hC0E4));
    sys_rst = 1;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 0;
    st = 8'h18;
    for (int bn = 0; bn < 32; bn++) begin
      step(1, 1, 8, bn);
      for (int o = 32; o < 128; o++) step(1, 1, o, $urandom_range(255));
    end
    step(1, 1, 5, 8'h03);
    step(1, 1, 4, 8'h25);
    step(1, 1, 0, 8'h5A);
    step(1, 0, 0, 0);
    step(1, 1, 8, 6);
    step(1, 0, 8'h25, 0);
    for (int i = 0; i < 3000; i++) step(1, $urandom_range(1), $urandom_range(127),
      $urandom_range(255));
    step(0, 0, 0, 0, 1, 8'h0F, 8'h01);
    step(0, 0, 0, 0, 1, 8'hFF, 8'h01);
    step(0, 0, 0, 0, 2, 8'h05, 8'h05);
    step(0, 0, 0, 0, 2, 8'h00, 8'h01);
    for (int i = 0; i < 60; i++) step(0, 0, 0, 0, 1 + i % 3, $urandom_range(255),
      $urandom_range(255));
    step(1, 1, 8'h30, 0, 1, 8'h12, 8'h34);
    step(1, 0, 8'h30, 0);
    step(1, 1, 3, 0, 3, 0, 0);
    step(1, 1, 3, 8'hFF);
    foreach (evTab[e]) step(0, 0, 0, 0, 0, 0, 0, evTab[e]);
    step(0, 0, 0, 0);
    finish_test();
  end
endmodule
